// ===== aso_serial_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Sync format select high gives an active-high frame sync after each convert taken while idle.
// - Select low gives active-low sync after reset; reset itself holds frame_sync low in both settings; nothing else changes.
// - Results leave serial_data_out most significant bit first, always.
// - Cascade mode sends both channels back to back as one 32-bit word.
// - Both channel inputs are sampled together on each convert command that arrives while idle; converts during a frame are ignored.
// - Convert emits frame sync, then shifts out the previous conversion result.
// - Tag bits shift in at the far end while data shifts out.
module aso_serial_port
  import aso_pkg::*;
#(
  parameter int CH_BITS = aso_pkg::ASO_CH_BITS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link pins, far side owns clock and convert
  input wire logic transfer_clock,
  input wire logic convert_n,
  input wire logic tag_in,
  // Configuration straps
  input wire logic sync_format_select,
  input wire logic cascade_mode,
  input wire logic channel_b_select,
  // Conversion core results
  input wire logic [CH_BITS-1:0] result_a,
  input wire logic [CH_BITS-1:0] result_b,
  // Link outputs
  output logic frame_sync,
  output logic serial_data_out,
  // Core side
  output logic sample_strobe,
  output logic busy
);
  import aso_pkg::*;

  localparam int SR_W = 2 * CH_BITS;

  aso_sync_if evt ();

  aso_state_t state_r;
  logic [SR_W-1:0] shift_r;
  logic [SR_W-1:0] held_r;
  logic [ASO_CNT_W-1:0] bits_left_r;
  logic sync_active_r;

  function automatic logic [ASO_CNT_W-1:0] word_len(input logic casc);
    word_len = casc ? ASO_CNT_W'(SR_W) : ASO_CNT_W'(CH_BITS);
  endfunction

  aso_pin_sync u_pin_sync
  (
    .clk(clk),
    .reset_n(reset_n),
    .transfer_clock(transfer_clock),
    .convert_n(convert_n),
    .tag_in(tag_in),
    .evt(evt)
  );

  // Far side owns all timing; we only follow its edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ASO_IDLE;
    end
    else
    begin
      case (state_r)
        ASO_IDLE:
        begin
          if (evt.convert)
            state_r <= ASO_SYNC;
        end
        ASO_SYNC:
        begin
          if (evt.clk_fall && sync_active_r)
            state_r <= ASO_SHIFT;
        end
        ASO_SHIFT:
        begin
          if (evt.clk_fall && bits_left_r == ASO_CNT_W'(1))
            state_r <= ASO_IDLE;
        end
        default:
        begin
          state_r <= ASO_IDLE;
        end
      endcase
    end
  end

  // Sync spans one transfer clock high phase, set on rise then dropped on the next fall
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_active_r <= 1'b0;
    else if (state_r == ASO_SYNC && evt.clk_rise)
      sync_active_r <= 1'b1;
    else if (evt.clk_fall && sync_active_r)
      sync_active_r <= 1'b0;
  end

  // Both channels latched in the same cycle; held for the next frame
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      held_r <= '0;
    else if (evt.convert && state_r == ASO_IDLE)
      held_r <= {result_a, result_b};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= evt.convert && state_r == ASO_IDLE;
  end

  // Load previous result, then shift MSB out, tag in at the LSB end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      shift_r <= '0;
    else if (evt.convert && state_r == ASO_IDLE)
    begin
      if (cascade_mode)
        shift_r <= held_r;
      else if (channel_b_select)
        shift_r <= {held_r[CH_BITS-1:0], {CH_BITS{1'b0}}};
      else
        shift_r <= {held_r[SR_W-1:CH_BITS], {CH_BITS{1'b0}}};
    end
    else if (state_r == ASO_SHIFT && evt.clk_fall)
      shift_r <= {shift_r[SR_W-2:0], evt.tag_bit};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bits_left_r <= ASO_CNT_RST;
    else if (evt.convert && state_r == ASO_IDLE)
      bits_left_r <= word_len(cascade_mode);
    else if (state_r == ASO_SHIFT && evt.clk_fall)
      bits_left_r <= bits_left_r - ASO_CNT_W'(1);
  end

  // Registered pins; polarity only touches the sync level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_sync <= ASO_SYNC_IDLE_HI;
      serial_data_out <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      frame_sync <= sync_active_r ~^ sync_format_select;
      serial_data_out <= (state_r == ASO_SHIFT) ? shift_r[SR_W-1] : 1'b0;
      busy <= state_r != ASO_IDLE;
    end
  end
endmodule

// ===== aso_pkg.sv
package aso_pkg;
  // Result width per channel and cascade word width
  localparam int ASO_CH_BITS = 16;
  localparam int ASO_WORD_BITS = 32;
  localparam int ASO_CNT_W = 6;
  localparam logic [ASO_CNT_W-1:0] ASO_CNT_RST = 6'h00;
  localparam logic ASO_SYNC_IDLE_HI = 1'b0;
  typedef enum logic [1:0] {
    ASO_IDLE = 2'b00,
    ASO_SYNC = 2'b01,
    ASO_SHIFT = 2'b10
  } aso_state_t;
endpackage

// ===== aso_sync_if.sv
`timescale 1ns/1ps
interface aso_sync_if;
  logic clk_rise;
  logic clk_fall;
  logic convert;
  logic tag_bit;
  modport edge_src (output clk_rise, output clk_fall, output convert, output tag_bit);
  modport edge_dst (input clk_rise, input clk_fall, input convert, input tag_bit);
endinterface

// ===== aso_pin_sync.sv
`timescale 1ns/1ps
module aso_pin_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pins
  input wire logic transfer_clock,
  input wire logic convert_n,
  input wire logic tag_in,
  // Synchronised events
  aso_sync_if.edge_src evt
);
  logic [1:0] tclk_sync_r;
  logic [1:0] conv_sync_r;
  logic [1:0] tag_sync_r;
  logic tclk_prev_r;
  logic conv_prev_r;

  // Two flops per pin; only the second stage feeds edge logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tclk_sync_r <= 2'h0;
      conv_sync_r <= 2'h3;
      tag_sync_r <= 2'h0;
    end
    else
    begin
      tclk_sync_r <= {tclk_sync_r[0], transfer_clock};
      conv_sync_r <= {conv_sync_r[0], convert_n};
      tag_sync_r <= {tag_sync_r[0], tag_in};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tclk_prev_r <= 1'b0;
      conv_prev_r <= 1'b1;
    end
    else
    begin
      tclk_prev_r <= tclk_sync_r[1];
      conv_prev_r <= conv_sync_r[1];
    end
  end

  assign evt.clk_rise = tclk_sync_r[1] & ~tclk_prev_r;
  assign evt.clk_fall = ~tclk_sync_r[1] & tclk_prev_r;
  // Convert command is the falling edge of convert_n
  assign evt.convert = ~conv_sync_r[1] & conv_prev_r;
  assign evt.tag_bit = tag_sync_r[1];
endmodule

// ===== aso_serial_port_properties.sv
`timescale 1ns/1ps
module aso_serial_port_properties
(
  // Clock, reset, pins in
  input wire logic clk,
  input wire logic reset_n,
  input wire logic convert_n,
  input wire logic sync_format_select,
  // Outputs watched
  input wire logic frame_sync,
  input wire logic serial_data_out,
  input wire logic sample_strobe,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_sync_on;
    busy && frame_sync == sync_format_select;
  endsequence
  sequence s_sync_off;
    frame_sync != sync_format_select;
  endsequence
  a_strobe_one_cycle: assert property (sample_strobe |=> !sample_strobe) else $error("strobe long");
  a_strobe_from_convert: assert property (sample_strobe |-> !convert_n && !$past(convert_n, 2)) else $error("strobe");
  a_busy_with_strobe: assert property ($rose(busy) |-> $past(sample_strobe)) else $error("busy rose");
  a_no_strobe_busy: assert property (sample_strobe |-> !$past(busy)) else $error("strobe in frame");
  a_sync_only_frame: assert property ($past(reset_n) && $stable(sync_format_select) && frame_sync == sync_format_select
    |-> busy) else $error("sync idle");
  a_sync_one_bit: assert property ($rose(busy && frame_sync == sync_format_select) |-> s_sync_on[*3] ##[1:3] s_sync_off)
    else $error("sync width");
  a_idle_data_low: assert property (!busy |-> !serial_data_out) else $error("data idle");
  a_frame_long: assert property ($rose(busy) |-> busy[*8]) else $error("frame short");
endmodule
bind aso_serial_port aso_serial_port_properties chk (.clk(clk), .reset_n(reset_n), .convert_n(convert_n),
  .sync_format_select(sync_format_select), .frame_sync(frame_sync), .serial_data_out(serial_data_out),
  .sample_strobe(sample_strobe), .busy(busy));

// ===== aso_far_end.sv
`timescale 1ns/1ps
module aso_far_end
(
  // Clock in
  input wire logic clk,
  // Pins driven
  output logic transfer_clock,
  output logic convert_n,
  output logic tag_in,
  // Pins received
  input wire logic frame_sync,
  input wire logic serial_data_out
);
  logic [31:0] word_r;
  logic sync_seen_r;
  initial
  begin
    transfer_clock = 1'b0;
    convert_n = 1'b1;
    tag_in = 1'b0;
  end
  // Bit clock stands low outside frames
  task automatic frame(input int n);
    word_r = 32'h0000_0000;
    @(posedge clk) convert_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int k = 0; k <= n; k++)
    begin
      transfer_clock <= 1'b1;
      tag_in <= k[0];
      repeat (2) @(posedge clk);
      if (k > 0)
        word_r = {word_r[30:0], serial_data_out};
      repeat (2) @(posedge clk);
      transfer_clock <= 1'b0;
      repeat (2) @(posedge clk);
      if (k == 0)
        sync_seen_r = frame_sync;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    convert_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ===== tb_aso_serial_port.sv
`timescale 1ns/1ps
module tb_aso_serial_port;
  logic clk, reset_n, transfer_clock, convert_n, tag_in, sync_format_select, cascade_mode, channel_b_select;
  logic frame_sync, serial_data_out, sample_strobe, busy;
  logic [15:0] result_a, result_b;
  int bad_count;
  int check_count;
  aso_serial_port dut (.*);
  aso_far_end p (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Word sent is the one captured at the convert before
  task automatic run(input logic s, input logic c, input logic b, input logic [31:0] ab, input logic [31:0] exp);
    @(posedge clk);
    sync_format_select <= s;
    cascade_mode <= c;
    channel_b_select <= b;
    {result_a, result_b} <= ab;
    repeat (2) @(posedge clk);
    p.frame(c ? 32 : 16);
    check(p.word_r, exp);
    check({31'h0, p.sync_seen_r}, {31'h0, s});
  endtask
  task automatic test_cascade_high;
    run(1'b1, 1'b1, 1'b0, 32'h1234_ABCD, 32'h0000_0000);
    run(1'b1, 1'b1, 1'b0, 32'h8001_7FFE, 32'h1234_ABCD);
  endtask
  task automatic test_polarity_low;
    run(1'b0, 1'b1, 1'b0, 32'hF00F_0FF0, 32'h8001_7FFE);
  endtask
  task automatic test_single_b;
    run(1'b0, 1'b0, 1'b1, 32'h5555_AAAA, 32'h0000_0FF0);
    run(1'b1, 1'b0, 1'b1, 32'h1111_2222, 32'h0000_AAAA);
    run(1'b1, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_1111);
  endtask
  initial
  begin
    reset_n = 1'b0;
    sync_format_select = 1'b1;
    cascade_mode = 1'b1;
    channel_b_select = 1'b0;
    result_a = 16'h0000;
    result_b = 16'h0000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_cascade_high();
    test_polarity_low();
    test_single_b();
    give_verdict();
  end
  // Six frames take about 34 us
  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule
